// ===== hw/vme_dma_defines.vh
// Purpose: Constants shared by the VME block-transfer engine files.
// Assumes: Included by its bare name from the engine, checker and bench files.
// Notes: Holds register selects, command fields, width codes and resets.
`ifndef VME_DMA_DEFINES_VH
`define VME_DMA_DEFINES_VH

// Register selects on both write ports.
`define SEL_LOCAL_ADDR 2'h0
`define SEL_VME_ADDR 2'h1
`define SEL_COMMAND 2'h2

// Command word fields.
`define CMD_LEN_MSB 15
`define CMD_LEN_LSB 0
`define CMD_WIDTH_MSB 18
`define CMD_WIDTH_LSB 16
`define CMD_AMODE_MSB 20
`define CMD_AMODE_LSB 19
`define CMD_AM_MSB 26
`define CMD_AM_LSB 21
`define CMD_DIR_BIT 27
`define CMD_RDAHEAD_BIT 28
`define CMD_POSTED_BIT 29
`define CMD_FIXED_BIT 30

// Data width codes.
`define WID_D08E 3'h0
`define WID_D08O 3'h1
`define WID_D16 3'h2
`define WID_D32 3'h3
`define WID_BLT 3'h4
`define WID_MBLT 3'h5

// Address mode codes.
`define AMODE_A16 2'h0
`define AMODE_A24 2'h1
`define AMODE_A32 2'h2

// Reset values.
`define RST_ADDR 32'h0000_0000
`define RST_CMD 32'h0000_0000
`define RST_DATA 64'h0000_0000_0000_0000

`endif

// ===== hw/pin_sync.v
// Purpose: Three-stage synchroniser with a debounced level and a rise pulse.
// Assumes: One clock, sys_clk; the input is an asynchronous pin.
// Notes: A change counts once the second and third stages agree.
`timescale 1ns/1ns
module pin_sync (
  input wire sys_clk,
  input wire rst_n,
  input wire pin_in,
  output wire level,
  output wire rise
);

  // Stage registers; the first is read only by the second.
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  // Accepted level and its one-cycle rise pulse.
  reg level_reg;
  reg rise_reg;

  // Shift the pin through the chain and accept agreed changes.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Only an agreed value moves the accepted level.
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
        rise_reg <= s3_reg & ~level_reg;
      end else begin
        rise_reg <= 1'b0;
      end
    end
  end

  assign level = level_reg;
  assign rise = rise_reg;

endmodule

// ===== hw/vme_block_dma_handler.v
// Purpose: Block-transfer engine between the local bus and the VMEbus.
// Assumes: 10 MHz sys_clk, synchronous active-low rst_n; VME pins are async.
// Notes: One holding register decouples the producing and consuming sides.
//
// Overview of operation
// - Both local and VME ports write control registers.
// - VME address width selectable: A16, A24, A32.
// - Supports D08 even/odd, D16, D32, BLT, MBLT.
// - Length programmed and counted in VME beats.
// - Read-ahead and posted writes overlap bus cycles.
// - Direction selects VME read or VME write.
// - Fixed option keeps local address constant.
// - VME write: local source, VME destination.
// - VME read: VME source, local destination.
// - Command holds width, length and address modifier.
// - Request bus; no data cycle before grant.
// - Done flag set on successful completion.
// - Error flag set on any detected error.
// - Local address is a full 32 bits.
`timescale 1ns/1ns
`include "vme_dma_defines.vh"
module vme_block_dma_handler (
  input wire sys_clk,
  input wire rst_n,
  // Register write port from the local bus host.
  input wire loc_wr,
  input wire [1:0] loc_sel,
  input wire [31:0] loc_wdata,
  // Register write port from the VME slave decoder.
  input wire vme_wr,
  input wire [1:0] vme_sel,
  input wire [31:0] vme_wdata,
  // Status flags and their clears.
  input wire done_clr,
  input wire error_clr,
  output wire transfer_done_flag,
  output wire transfer_error_flag,
  output wire busy,
  // Bus requester handshake (grant is a pin).
  output wire bus_req,
  input wire bus_grant,
  // VME data cycle handshake toward the master pins.
  output wire vme_cyc_req,
  output wire vme_cyc_write,
  output wire [31:0] vme_cyc_addr,
  output wire [5:0] vme_cyc_am,
  output wire [2:0] vme_cyc_width,
  output wire [63:0] vme_cyc_wdata,
  input wire vme_cyc_ack,
  input wire vme_cyc_berr,
  input wire [63:0] vme_cyc_rdata,
  // Synchronous local bus master.
  output wire lbus_req,
  output wire lbus_write,
  output wire [31:0] lbus_addr,
  output wire [2:0] lbus_width,
  output wire [63:0] lbus_wdata,
  input wire lbus_ack,
  input wire [63:0] lbus_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // States, one-hot.
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_REQ = 4'b0010;
  localparam [3:0] ST_RUN = 4'b0100;
  localparam [3:0] ST_END = 4'b1000;

  reg [3:0] state_reg;
  // Programmed registers; the local address is a full 32 bits.
  reg [31:0] local_start_addr_reg;
  reg [31:0] vme_start_addr_reg;
  reg [31:0] cmd_reg;
  // Running addresses and beat counters.
  reg [31:0] laddr_reg;
  reg [31:0] vaddr_reg;
  reg [15:0] prod_left_reg;
  reg [15:0] cons_left_reg;
  // Holding register between the two sides.
  reg [63:0] hold_reg;
  reg hold_valid_reg;
  // Side activity and the error seen on this transfer.
  reg vme_busy_reg;
  reg lb_busy_reg;
  reg berr_seen_reg;
  // Output registers.
  reg done_reg;
  reg error_reg;
  reg bus_req_reg;
  reg cyc_req_reg;
  reg [31:0] cyc_addr_reg;
  reg [63:0] cyc_wdata_reg;
  reg lreq_reg;
  reg [31:0] lout_addr_reg;
  reg [63:0] lwdata_reg;

  // Synchronised pins.
  wire grant_lvl;
  wire ack_lvl;
  wire ack_rise;
  wire berr_lvl;
  wire berr_rise;

  pin_sync u_grant (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(bus_grant),
    .level(grant_lvl), .rise());
  pin_sync u_ack (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(vme_cyc_ack),
    .level(ack_lvl), .rise(ack_rise));
  pin_sync u_berr (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(vme_cyc_berr),
    .level(berr_lvl), .rise(berr_rise));

  ////////////////////////////////////////////////////////////////////////////
  // Command fields.
  wire vme_write_dir = cmd_reg[`CMD_DIR_BIT];
  wire [2:0] width = cmd_reg[`CMD_WIDTH_MSB:`CMD_WIDTH_LSB];
  wire [1:0] amode = cmd_reg[`CMD_AMODE_MSB:`CMD_AMODE_LSB];
  // Overlap means read-ahead for VME writes, posted writes for VME reads.
  wire overlap = vme_write_dir ? cmd_reg[`CMD_RDAHEAD_BIT] :
    cmd_reg[`CMD_POSTED_BIT];

  // Bytes per beat for the selected width.
  reg [31:0] step;
  always @* begin
    case (width)
      `WID_D08E: step = 32'h0000_0001;
      `WID_D08O: step = 32'h0000_0001;
      `WID_D16: step = 32'h0000_0002;
      `WID_MBLT: step = 32'h0000_0008;
      default: step = 32'h0000_0004;
    endcase
  end

  // VME address cut to the selected address width.
  reg [31:0] vaddr_out;
  always @* begin
    case (amode)
      `AMODE_A16: vaddr_out = {16'h0000, vaddr_reg[15:0]};
      `AMODE_A24: vaddr_out = {8'h00, vaddr_reg[23:0]};
      default: vaddr_out = vaddr_reg;
    endcase
  end

  // A VME cycle may start only while the grant is held and the last ack is gone.
  wire vme_free = !vme_busy_reg && grant_lvl && !ack_lvl && !berr_lvl;
  wire running = state_reg[2] && !berr_seen_reg;
  // Producer: local read for VME writes, VME read for VME reads.
  wire prod_go = running && !hold_valid_reg && (prod_left_reg != 16'h0000) &&
    (vme_write_dir ?
      (!lb_busy_reg && (overlap || !vme_busy_reg)) :
      (vme_free && (overlap || !lb_busy_reg)));
  // Consumer: VME write for VME writes, local write for VME reads.
  wire cons_go = running && hold_valid_reg &&
    (vme_write_dir ? vme_free : !lb_busy_reg);
  wire vme_go = vme_write_dir ? cons_go : prod_go;
  wire lb_go = vme_write_dir ? prod_go : cons_go;
  wire vme_end = vme_busy_reg && (ack_rise || berr_rise);
  wire lb_end = lb_busy_reg && lbus_ack;

  // One command write per cycle; the local host wins a collision.
  wire any_wr = loc_wr || vme_wr;
  wire [1:0] wsel = loc_wr ? loc_sel : vme_sel;
  wire [31:0] wdata = loc_wr ? loc_wdata : vme_wdata;
  wire start = any_wr && (wsel == `SEL_COMMAND) && state_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, writable from either port while idle.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      local_start_addr_reg <= `RST_ADDR;
      vme_start_addr_reg <= `RST_ADDR;
      cmd_reg <= `RST_CMD;
    end else if (any_wr && state_reg[0]) begin
      // Writes while a transfer runs are ignored.
      case (wsel)
        `SEL_LOCAL_ADDR: local_start_addr_reg <= wdata;
        `SEL_VME_ADDR: vme_start_addr_reg <= wdata;
        `SEL_COMMAND: cmd_reg <= wdata;
        default: cmd_reg <= cmd_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, side engines, holding register and flags.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      laddr_reg <= `RST_ADDR;
      vaddr_reg <= `RST_ADDR;
      prod_left_reg <= 16'h0000;
      cons_left_reg <= 16'h0000;
      hold_reg <= `RST_DATA;
      hold_valid_reg <= 1'b0;
      vme_busy_reg <= 1'b0;
      lb_busy_reg <= 1'b0;
      berr_seen_reg <= 1'b0;
      done_reg <= 1'b0;
      error_reg <= 1'b0;
      bus_req_reg <= 1'b0;
      cyc_req_reg <= 1'b0;
      cyc_addr_reg <= `RST_ADDR;
      cyc_wdata_reg <= `RST_DATA;
      lreq_reg <= 1'b0;
      lout_addr_reg <= `RST_ADDR;
      lwdata_reg <= `RST_DATA;
    end else begin
      // Software clears; a set later in this block wins over the clear.
      if (done_clr) begin
        done_reg <= 1'b0;
      end
      if (error_clr) begin
        error_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            // Writing the command starts; addresses were loaded before.
            laddr_reg <= local_start_addr_reg;
            vaddr_reg <= vme_start_addr_reg;
            prod_left_reg <= wdata[`CMD_LEN_MSB:`CMD_LEN_LSB];
            cons_left_reg <= wdata[`CMD_LEN_MSB:`CMD_LEN_LSB];
            hold_valid_reg <= 1'b0;
            berr_seen_reg <= 1'b0;
            bus_req_reg <= 1'b1;
            state_reg <= ST_REQ;
          end
        end
        ST_REQ: begin
          // Wait for ownership before any data cycle.
          if (grant_lvl) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          // Finish once every beat is consumed or a bus error ended it.
          if ((cons_left_reg == 16'h0000 || berr_seen_reg) &&
              !vme_busy_reg && !lb_busy_reg) begin
            state_reg <= ST_END;
          end
        end
        ST_END: begin
          // Release the bus and raise exactly one outcome flag.
          bus_req_reg <= 1'b0;
          if (berr_seen_reg) begin
            error_reg <= 1'b1;
          end else begin
            done_reg <= 1'b1;
          end
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase

      // Launch a VME cycle; source or destination is the VME address.
      if (vme_go) begin
        vme_busy_reg <= 1'b1;
        cyc_req_reg <= 1'b1;
        cyc_addr_reg <= vaddr_out;
        cyc_wdata_reg <= hold_reg;
      end
      // Launch a local cycle; local address is the other end.
      if (lb_go) begin
        lb_busy_reg <= 1'b1;
        lreq_reg <= 1'b1;
        lout_addr_reg <= laddr_reg;
        lwdata_reg <= hold_reg;
      end
      // A consumer launch empties the holding register.
      if (cons_go) begin
        hold_valid_reg <= 1'b0;
      end

      // VME cycle end: advance on success, stop on a bus error.
      if (vme_end) begin
        vme_busy_reg <= 1'b0;
        cyc_req_reg <= 1'b0;
        if (berr_rise) begin
          berr_seen_reg <= 1'b1;
        end else begin
          vaddr_reg <= vaddr_reg + step;
          if (vme_write_dir) begin
            cons_left_reg <= cons_left_reg - 16'h0001;
          end else begin
            prod_left_reg <= prod_left_reg - 16'h0001;
            hold_reg <= vme_cyc_rdata;
            hold_valid_reg <= 1'b1;
          end
        end
      end

      // Local cycle end: advance unless the local address is fixed.
      if (lb_end) begin
        lb_busy_reg <= 1'b0;
        lreq_reg <= 1'b0;
        if (!cmd_reg[`CMD_FIXED_BIT]) begin
          laddr_reg <= laddr_reg + step;
        end
        if (vme_write_dir) begin
          prod_left_reg <= prod_left_reg - 16'h0001;
          hold_reg <= lbus_rdata;
          hold_valid_reg <= 1'b1;
        end else begin
          cons_left_reg <= cons_left_reg - 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from registers.
  assign transfer_done_flag = done_reg;
  assign transfer_error_flag = error_reg;
  assign busy = ~state_reg[0];
  assign bus_req = bus_req_reg;
  assign vme_cyc_req = cyc_req_reg;
  assign vme_cyc_write = cmd_reg[`CMD_DIR_BIT];
  assign vme_cyc_addr = cyc_addr_reg;
  assign vme_cyc_am = cmd_reg[`CMD_AM_MSB:`CMD_AM_LSB];
  assign vme_cyc_width = cmd_reg[`CMD_WIDTH_MSB:`CMD_WIDTH_LSB];
  assign vme_cyc_wdata = cyc_wdata_reg;
  assign lbus_req = lreq_reg;
  assign lbus_write = ~cmd_reg[`CMD_DIR_BIT];
  assign lbus_addr = lout_addr_reg;
  assign lbus_width = cmd_reg[`CMD_WIDTH_MSB:`CMD_WIDTH_LSB];
  assign lbus_wdata = lwdata_reg;

endmodule

// ===== dv/vme_dma_checks_asserts.sv
// Purpose: Port checker for the block-transfer engine.
// Assumes: One clock, synchronous active-low reset.
// Notes: Attached by the bind at the foot of this file.
`timescale 1ns/1ns
`include "vme_dma_defines.vh"
module dma_checks (
  input wire sys_clk,
  input wire rst_n,
  input wire loc_wr,
  input wire [1:0] loc_sel,
  input wire vme_wr,
  input wire [1:0] vme_sel,
  input wire busy,
  input wire bus_req,
  input wire bus_grant,
  input wire transfer_done_flag,
  input wire transfer_error_flag,
  input wire vme_cyc_req,
  input wire vme_cyc_write,
  input wire [31:0] vme_cyc_addr,
  input wire [2:0] vme_cyc_width,
  input wire vme_cyc_berr,
  input wire lbus_req,
  input wire lbus_write
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////
  reg [31:0] prev_addr; // Address of the previous beat.
  reg prev_ok; // Cleared between transfers so a new start is not stepped.
  reg [3:0] step; // Bytes per beat for the current width.
  wire [31:0] next_addr = prev_addr + {28'h000_0000, step}; // Where the next beat must start.
  // Byte step per width code.
  always @* begin
    case (vme_cyc_width)
      `WID_D08E, `WID_D08O: step = 4'h1;
      `WID_D16: step = 4'h2;
      `WID_MBLT: step = 4'h8;
      default: step = 4'h4;
    endcase
  end
  // Remember each beat start while the engine is busy.
  always @(posedge sys_clk) begin
    if (!rst_n || !busy) begin
      prev_ok <= 1'h0;
    end else if ($rose(vme_cyc_req)) begin
      prev_ok <= 1'h1;
    end
    if ($rose(vme_cyc_req)) begin
      prev_addr <= vme_cyc_addr;
    end
  end
  ////////////////////////////////
  sequence loc_cmd;
    loc_wr && loc_sel == `SEL_COMMAND && !busy;
  endsequence
  sequence vme_cmd;
    vme_wr && !loc_wr && vme_sel == `SEL_COMMAND && !busy;
  endsequence
  sequence berr_hit;
    vme_cyc_req && vme_cyc_berr;
  endsequence
  // After an abort the VME side stays silent and no done flag appears.
  sequence quiet_after;
    (!vme_cyc_req && !$rose(transfer_done_flag)) [*8];
  endsequence
  // At least one outcome flag is up and the bus is already released.
  sequence flag_up;
    (transfer_done_flag || transfer_error_flag) && !bus_req;
  endsequence
  // A later beat of the same transfer starts.
  sequence beat_again;
    $rose(vme_cyc_req) && prev_ok;
  endsequence
  a_local_cmd_start: assert property (loc_cmd |=> busy && bus_req)
    else $error("local command did not start");
  a_remote_cmd_start: assert property (vme_cmd |=> busy && bus_req)
    else $error("remote command did not start");
  a_grant_first: assert property ($rose(vme_cyc_req) |-> bus_req && $past(bus_grant, 3))
    else $error("cycle began without grant");
  a_idle_quiet: assert property (!busy |-> !vme_cyc_req && !lbus_req && !bus_req)
    else $error("activity while idle");
  a_berr_flag: assert property (berr_hit |-> ##[1:20] transfer_error_flag)
    else $error("bus error not flagged");
  a_berr_stops: assert property (berr_hit |-> ##[1:6] quiet_after)
    else $error("transfer went on after bus error");
  a_end_flags: assert property ($fell(busy) |-> flag_up)
    else $error("transfer ended without flag");
  a_dir_pair: assert property (lbus_req && vme_cyc_req |-> lbus_write != vme_cyc_write)
    else $error("local and VME direction agree");
  a_addr_step: assert property (beat_again |-> vme_cyc_addr == next_addr)
    else $error("VME address step wrong");
endmodule
bind vme_block_dma_handler dma_checks u_checks (.sys_clk, .rst_n, .loc_wr, .loc_sel,
  .vme_wr, .vme_sel, .busy, .bus_req, .bus_grant, .transfer_done_flag, .transfer_error_flag,
  .vme_cyc_req, .vme_cyc_write, .vme_cyc_addr, .vme_cyc_width, .vme_cyc_berr, .lbus_req,
  .lbus_write);

// ===== dv/vme_slave_model.sv
// Purpose: Behavioural VME slave and arbiter facing the engine.
// Assumes: Pins change on the falling edge; one beat per handshake.
// Notes: Read data toggles while no cycle is requested, so stale data never matches.
`timescale 1ns/1ns
module vme_slave_model (
  input wire sys_clk,
  input wire bus_req,
  input wire vme_cyc_req,
  input wire [31:0] vme_cyc_addr,
  input wire [3:0] wait_cycles,
  input wire fail_now,
  output reg bus_grant = 1'h0,
  output reg vme_cyc_ack = 1'h0,
  output reg vme_cyc_berr = 1'h0,
  output reg [63:0] vme_cyc_rdata = 64'h0000_0000_0000_0000
);
  reg [3:0] cnt = 4'h0; // Wait states spent on this beat.
  // Four-phase answer: strobe high after the wait, low once the request drops.
  always @(negedge sys_clk) begin
    bus_grant <= bus_req;
    if (!vme_cyc_req) begin
      cnt <= 4'h0;
      vme_cyc_ack <= 1'h0;
      vme_cyc_berr <= 1'h0;
      vme_cyc_rdata <= ~vme_cyc_rdata;
    end else if (cnt <= wait_cycles) begin
      // At least one wait, so the bench has counted this beat before fail_now is read.
      cnt <= cnt + 4'h1;
    end else begin
      vme_cyc_ack <= !fail_now;
      vme_cyc_berr <= fail_now;
      vme_cyc_rdata <= {vme_cyc_addr, ~vme_cyc_addr};
    end
  end
endmodule

// ===== dv/test_vme_block_dma_handler.sv
// Purpose: Self-checking bench for the block-transfer engine.
// Assumes: 10 MHz clock; local memory answered here, VME by the model.
// Notes: Table rows first, then bus error and reset cases.
`timescale 1ns/1ns
`include "vme_dma_defines.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module test_vme_block_dma_handler;
  reg sys_clk = 1'h0, rst_n = 1'h0, loc_wr = 1'h0, vme_wr = 1'h0;
  reg done_clr = 1'h0, error_clr = 1'h0, lbus_ack = 1'h0, vprev = 1'h0;
  reg [1:0] loc_sel = 2'h0, vme_sel = 2'h0;
  reg [31:0] loc_wdata = 32'h0000_0000, vme_wdata = 32'h0000_0000, v_last, l_last;
  reg [63:0] lbus_rdata = 64'h0000_0000_0000_0000, vd_last, ld_last;
  reg [3:0] wait_cycles = 4'h0; // Slave wait states, varied per row.
  reg [5:0] v_am;
  reg [2:0] v_wid, l_wid; // Widths seen on the last beat of each side.
  reg v_wr, l_wr, both; // Directions, and both sides seen busy in one cycle.
  int fail_at = 99, errors = 0, tests_run = 0, vcnt = 0, lcnt = 0;
  wire busy, bus_req, bus_grant, vme_cyc_req, vme_cyc_write, vme_cyc_ack, vme_cyc_berr;
  wire transfer_done_flag, transfer_error_flag, lbus_req, lbus_write;
  wire [31:0] vme_cyc_addr, lbus_addr;
  wire [5:0] vme_cyc_am;
  wire [2:0] vme_cyc_width, lbus_width;
  wire [63:0] vme_cyc_wdata, vme_cyc_rdata, lbus_wdata;
  // Rows: port (0 local, 1 VME, 2 both), local addr, VME addr, command.
  reg [97:0] rows [7] = '{
    {2'h0, 32'h0000_1000, 32'h4000_0100, 32'h0520_0003},
    {2'h1, 32'h2000_0000, 32'h12AB_CD00, 32'h0F29_0002},
    {2'h2, 32'h8000_0100, 32'h4000_0100, 32'h2132_0004},
    {2'h0, 32'hFF00_0010, 32'h0000_2000, 32'h58B3_0003},
    {2'h0, 32'h0100_0000, 32'h0030_0000, 32'h476C_0005},
    {2'h1, 32'h0000_8000, 32'h4000_0000, 32'h3915_0004},
    {2'h0, 32'h0000_0000, 32'h0000_0000, 32'h0133_0000}};
  vme_block_dma_handler u_dut (.sys_clk, .rst_n, .loc_wr, .loc_sel, .loc_wdata, .vme_wr,
    .vme_sel, .vme_wdata, .done_clr, .error_clr, .transfer_done_flag, .transfer_error_flag,
    .busy, .bus_req, .bus_grant, .vme_cyc_req, .vme_cyc_write, .vme_cyc_addr, .vme_cyc_am,
    .vme_cyc_width, .vme_cyc_wdata, .vme_cyc_ack, .vme_cyc_berr, .vme_cyc_rdata, .lbus_req,
    .lbus_write, .lbus_addr, .lbus_width, .lbus_wdata, .lbus_ack, .lbus_rdata);
  vme_slave_model u_slave (.sys_clk, .bus_req, .vme_cyc_req, .vme_cyc_addr, .wait_cycles,
    .fail_now(vcnt == fail_at), .bus_grant, .vme_cyc_ack, .vme_cyc_berr, .vme_cyc_rdata);
  ////////////////////////////////
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Local memory: one-cycle acknowledge, data from the address, noise otherwise.
  always @(negedge sys_clk) begin
    lbus_ack <= lbus_req && !lbus_ack;
    lbus_rdata <= (lbus_req && !lbus_ack) ? {~lbus_addr, lbus_addr} : ~lbus_rdata;
  end
  // Record each VME beat start and each finished local beat.
  always @(posedge sys_clk) begin
    if (vme_cyc_req && !vprev) begin
      vcnt++;
      v_last = vme_cyc_addr;
      vd_last = vme_cyc_wdata;
      v_am = vme_cyc_am;
      v_wid = vme_cyc_width;
      v_wr = vme_cyc_write;
    end
    vprev = vme_cyc_req;
    // Overlap shows as a local cycle running while a VME cycle is open.
    if (lbus_req && vme_cyc_req) both = 1'h1;
    if (lbus_req && lbus_ack) begin
      lcnt++;
      l_last = lbus_addr;
      ld_last = lbus_wdata;
      l_wr = lbus_write;
      l_wid = lbus_width;
    end
  end
  ////////////////////////////////
  // One register write; with both ports the remote one carries junk and must lose.
  task automatic wr(input [1:0] p, input [1:0] s, input [31:0] d);
    @(negedge sys_clk);
    loc_wr = p != 2'h1;
    vme_wr = p != 2'h0;
    loc_sel = s;
    vme_sel = s;
    loc_wdata = d;
    vme_wdata = (p == 2'h2) ? ~d : d;
  endtask
  // Program addresses first, then the command, and wait for the engine to go idle.
  task automatic run(input [1:0] p, input [31:0] la, va, cmd);
    vcnt = 0;
    lcnt = 0;
    both = 1'h0;
    wr(p, `SEL_LOCAL_ADDR, la);
    wr(p, `SEL_VME_ADDR, va);
    wr(p, `SEL_COMMAND, cmd);
    @(negedge sys_clk);
    loc_wr = 1'h0;
    vme_wr = 1'h0;
    `CHK("busy", 1'h1, busy)
    for (int k = 0; k < 4000 && busy !== 1'h0; k++) @(negedge sys_clk);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    tally_and_finish;
  end
  ////////////////////////////////
  initial begin : main
    reg [1:0] p;
    reg [31:0] la, va, cmd, st, m;
    reg [63:0] dm;
    repeat (4) @(negedge sys_clk);
    // The cleared command selects a VME read, so the local side idles as a writer.
    `CHK("idle bus", 4'h0, {busy, bus_req, vme_cyc_req, lbus_req})
    `CHK("idle flags", 3'h1, {transfer_done_flag, transfer_error_flag, lbus_write})
    rst_n = 1'h1;
    for (int r = 0; r < 7; r++) begin
      {p, la, va, cmd} = rows[r];
      wait_cycles = 4'(r % 3);
      run(p, la, va, cmd);
      st = cmd[18:16] < 3'h2 ? 1 : cmd[18:16] == 3'h2 ? 2 : cmd[18:16] == 3'h5 ? 8 : 4;
      m = cmd[20:19] == 2'h0 ? 32'h0000_FFFF : cmd[20:19] == 2'h1 ? 32'h00FF_FFFF : '1;
      `CHK("done", 1'h1, transfer_done_flag)
      `CHK("error", 1'h0, transfer_error_flag)
      `CHK("vme beats", cmd[15:0], 16'(vcnt))
      `CHK("local beats", cmd[15:0], 16'(lcnt))
      if (cmd[15:0] != 16'h0000) begin
        `CHK("vme addr", (va + (cmd[15:0] - 1) * st) & m, v_last)
        `CHK("local addr", cmd[30] ? la : la + (cmd[15:0] - 1) * st, l_last)
        `CHK("am", cmd[26:21], v_am)
        `CHK("width", cmd[18:16], v_wid)
        `CHK("local width", cmd[18:16], l_wid)
        `CHK("vme write", cmd[27], v_wr)
        `CHK("local write", !cmd[27], l_wr)
        // Read-ahead must let the next local read run under an open VME write.
        if (cmd[27]) begin
          `CHK("overlap", cmd[28] && cmd[15:0] > 16'h0001, both)
        end
        dm = cmd[18:16] == 3'h5 ? '1 : 64'h0000_0000_FFFF_FFFF;
        if (cmd[18:16] >= 3'h3 && cmd[27])
          `CHK("vme data", {~l_last, l_last} & dm, vd_last & dm)
        if (cmd[18:16] >= 3'h3 && !cmd[27])
          `CHK("loc data", {v_last, ~v_last} & dm, ld_last & dm)
      end
      @(negedge sys_clk) done_clr = 1'h1;
      @(negedge sys_clk) done_clr = 1'h0;
      `CHK("done clear", 1'h0, transfer_done_flag)
    end
    fail_at = 3;
    run(2'h0, 32'h0000_4000, 32'h0000_0100, 32'h0133_0006);
    `CHK("error", 1'h1, transfer_error_flag)
    `CHK("done", 1'h0, transfer_done_flag)
    `CHK("beats", 3, vcnt)
    `CHK("bus req", 1'h0, bus_req)
    fail_at = 99;
    @(negedge sys_clk) error_clr = 1'h1;
    @(negedge sys_clk) error_clr = 1'h0;
    `CHK("error clear", 1'h0, transfer_error_flag)
    // Reset in mid-transfer drops everything; a fresh transfer must then complete.
    wr(2'h0, `SEL_LOCAL_ADDR, 32'h0000_0200);
    wr(2'h0, `SEL_VME_ADDR, 32'h0000_0080);
    wr(2'h0, `SEL_COMMAND, 32'h0133_0008);
    @(negedge sys_clk);
    loc_wr = 1'h0;
    repeat (20) @(negedge sys_clk);
    `CHK("busy mid run", 1'h1, busy)
    rst_n = 1'h0;
    repeat (4) @(negedge sys_clk);
    `CHK("reset bus", 4'h0, {busy, bus_req, vme_cyc_req, lbus_req})
    `CHK("reset flags", 3'h1, {transfer_done_flag, transfer_error_flag, lbus_write})
    rst_n = 1'h1;
    run(2'h1, 32'h0000_0300, 32'h0000_0040, 32'h0133_0002);
    `CHK("done after reset", 1'h1, transfer_done_flag)
    `CHK("beats after reset", 2, vcnt)
    tally_and_finish;
  end
endmodule
